// file: shared/softstart_regs.svh
/*
 * Command codes, field positions, reset values and timing counts for the
 * sync fault and soft-start controller.
 * Assumes a 125 MHz core clock; included by bare name.
 */
`ifndef SOFTSTART_REGS_SVH
`define SOFTSTART_REGS_SVH

`define CMD_RISE_TIME        8'h61
`define CMD_MFR_STATUS       8'h80
`define CMD_MISC_CFG         8'hF0

`define STAT_SYNC_FLT_BIT    0
`define STAT_STRAP_FAIL_BIT  3
`define MISC_LOSS_OFF_BIT    0
`define MISC_CFG_RESET       8'h00

`define RISE_DEFAULT_MS      8'h03
`define RISE_MIN_MS          8'h01
`define RISE_MAX_MS          8'h64

`define STRAP_CODE_RAIL      4'h9
`define STRAP_MATCH_COUNT    3'h4
`define STRAP_MAX_TRIES      5'h10

`define CLK_PERIOD_NS        8
`define LOSS_TIME_NS         10000
`define LOSS_CYC             (`LOSS_TIME_NS / `CLK_PERIOD_NS)
`define SLOW_TIME_NS         5000
`define SLOW_CYC             (`SLOW_TIME_NS / `CLK_PERIOD_NS)
`define ROLE_TIME_NS         10000
`define ROLE_CYC             (`ROLE_TIME_NS / `CLK_PERIOD_NS)
`define RESTORE_EDGES        3'h7
`define MS_NS                1000000
`define RAMP_STEPS           1024
`define STEP_CYC             (`MS_NS / `RAMP_STEPS / `CLK_PERIOD_NS)

`endif

// file: shared/softstart_pkg.sv
/*
 * Types shared by the sync fault and soft-start controller.
 * Assumes softstart_regs.svh supplies the numeric constants.
 */
`default_nettype none
package softstart_pkg;

	typedef enum logic [5:0] {
		ST_DETECT = 6'b000001,
		ST_STRAP  = 6'b000010,
		ST_OFF    = 6'b000100,
		ST_RAMP   = 6'b001000,
		ST_ON     = 6'b010000,
		ST_HOLD   = 6'b100000
	} ctrl_state_t;

	typedef struct packed {
		logic [7:0] code;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} cmd_req_t;

	typedef struct packed {
		logic       done;
		logic       fail;
		logic [7:0] rise_ms;
	} strap_result_t;

endpackage
`default_nettype wire

// file: hw/strap_decoder.sv
/*
 * Soft-start strap decoder: needs matching consecutive samples.
 * Assumes strap codes arrive on the core clock from a sampling converter.
 */
`include "softstart_regs.svh"
`default_nettype none
module strap_decoder
	import softstart_pkg::*;
(
	input  wire logic          core_clk_in,
	input  wire logic          reset_in,
	input  wire logic          strap_valid_in,
	input  wire logic [3:0]    strap_code_in,
	input  wire logic [7:0]    nvm_rise_in,
	output var  strap_result_t result_out
);

	logic [3:0] last_q;
	logic [2:0] match_q;
	logic [4:0] tries_q;
	logic [2:0] match_d;

	function automatic logic [7:0] strap_ms(input logic [3:0] code, input logic [7:0] nvm);
		case (code)
			4'h0: strap_ms = 8'h03;
			4'h1: strap_ms = 8'h01;
			4'h2: strap_ms = 8'h02;
			4'h3: strap_ms = 8'h03;
			4'h4: strap_ms = 8'h05;
			4'h5: strap_ms = 8'h07;
			4'h6: strap_ms = 8'h0A;
			4'h7: strap_ms = 8'h1B;
			4'h8: strap_ms = 8'h34;
			`STRAP_CODE_RAIL: strap_ms = nvm;
			default: strap_ms = 8'h00;
		endcase
	endfunction

	// invalid codes break a run of matches
	always_comb begin
		if (strap_code_in > `STRAP_CODE_RAIL)
			match_d = 3'h0;
		else if (match_q != 3'h0 && strap_code_in == last_q)
			match_d = match_q + 3'h1;
		else
			match_d = 3'h1;
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			last_q <= 4'h0;
			match_q <= 3'h0;
			tries_q <= 5'h00;
			result_out <= '0;
		end else if (strap_valid_in && !result_out.done) begin
			last_q <= strap_code_in;
			match_q <= match_d;
			tries_q <= tries_q + 5'h01;
			if (match_d == `STRAP_MATCH_COUNT) begin
				result_out.done <= 1'b1;
				result_out.rise_ms <= strap_ms(strap_code_in, nvm_rise_in);
			end else if (tries_q == `STRAP_MAX_TRIES - 5'h01) begin
				result_out.done <= 1'b1;
				result_out.fail <= 1'b1;
				result_out.rise_ms <= `RISE_DEFAULT_MS;
			end
		end
	end

	a_strap_fail_value: assert property (@(posedge core_clk_in) disable iff (reset_in)
		result_out.fail |-> result_out.done && result_out.rise_ms == 8'h03)
		else $error("strap failure did not fall back to 3 ms");

endmodule
`default_nettype wire

// file: hw/sync_fault_softstart_ctrl.sv
/*
 * Sync clock supervisor, fault line handling and soft-start ramp.
 * Assumes reset_in is the input power-up reset and the command port is
 * fed by a bus engine on the core clock.
 */
`include "softstart_regs.svh"
`default_nettype none
module sync_fault_softstart_ctrl
	import softstart_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,
	input  wire logic        sync_pin_in,
	input  wire logic        loop_slave_strap_in,
	input  wire logic        control_pin_in,
	input  wire logic        shared_loop_line_in,
	input  wire logic        fault_in,
	input  wire logic        strap_valid_in,
	input  wire logic [3:0]  strap_code_in,
	input  wire logic [7:0]  nvm_rise_in,
	input  wire logic [15:0] vref_target_in,
	input  wire cmd_req_t    cmd_req_in,
	output logic [7:0]       cmd_rdata_out,
	output logic             switch_enable_out,
	output logic             freq_slow_out,
	output logic             sync_out_oe_out,
	output logic             shared_loop_line_out,
	output logic             shared_loop_line_oe_out,
	output logic             alert_out,
	output logic             softstart_busy_out,
	output logic [15:0]      vref_out
);

	localparam int LOSS_I = `LOSS_CYC;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	logic          sync_meta_q;
	logic          sync_q;
	logic          sync_prev_q;
	logic          slave_meta_q;
	logic          slave_q;
	logic          ctrl_meta_q;
	logic          ctrl_q;
	logic          share_meta_q;
	logic          share_q;
	logic          slave_role_q;
	logic          clk_role_q;
	logic [10:0]   role_cnt_q;
	logic [10:0]   gap_q;
	logic [2:0]    restore_cnt_q;
	logic          clk_ok_q;
	logic          sync_edge;
	logic          loss_off;
	logic          sync_flt;
	logic          run_ok;
	ctrl_state_t   state_q;
	ctrl_state_t   state_d;
	strap_result_t strap;
	logic          strap_taken_q;
	logic          strap_fail_q;
	logic [7:0]    rise_q;
	logic [7:0]    misc_q;
	logic [13:0]   step_cnt_q;
	logic [13:0]   step_len;
	logic [10:0]   frac_q;
	logic [26:0]   vref_prod;
	logic          rise_wr_ok;

	strap_decoder u_strap (
		.core_clk_in    (core_clk_in),
		.reset_in       (reset_in),
		.strap_valid_in (strap_valid_in && state_q == ST_STRAP),
		.strap_code_in  (strap_code_in),
		.nvm_rise_in    (nvm_rise_in),
		.result_out     (strap)
	);

	// pins from outside the clock domain
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			sync_meta_q <= 1'b0;
			sync_q <= 1'b0;
			sync_prev_q <= 1'b0;
			slave_meta_q <= 1'b0;
			slave_q <= 1'b0;
			ctrl_meta_q <= 1'b0;
			ctrl_q <= 1'b0;
			share_meta_q <= 1'b1;
			share_q <= 1'b1;
		end else begin
			sync_meta_q <= sync_pin_in;
			sync_q <= sync_meta_q;
			sync_prev_q <= sync_q;
			slave_meta_q <= loop_slave_strap_in;
			slave_q <= slave_meta_q;
			ctrl_meta_q <= control_pin_in;
			ctrl_q <= ctrl_meta_q;
			share_meta_q <= shared_loop_line_in;
			share_q <= share_meta_q;
		end
	end

	// loop slave follows falling edges, everyone else rising
	assign sync_edge = slave_role_q ? (sync_prev_q && !sync_q) : (!sync_prev_q && sync_q);

	// role detection window right after power-up
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			role_cnt_q <= 11'h000;
			clk_role_q <= 1'b0;
			slave_role_q <= 1'b0;
		end else if (state_q == ST_DETECT) begin
			role_cnt_q <= role_cnt_q + 11'h001;
			if (slave_q)
				slave_role_q <= 1'b1;
			if (slave_q || sync_q || sync_edge)
				clk_role_q <= 1'b1;
		end
	end

	a_role_fixed: assert property (state_q != ST_DETECT |=> $stable(clk_role_q))
		else $error("clock role changed after detection");

	// gap since last edge; saturates at the loss count
	always_ff @(posedge core_clk_in) begin
		if (reset_in)
			gap_q <= 11'h000;
		else if (sync_edge)
			gap_q <= 11'h000;
		else if (gap_q != 11'(`LOSS_CYC))
			gap_q <= gap_q + 11'h001;
	end

	// starts as absent, so a clock-role phase that never sees the clock stays off
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			clk_ok_q <= 1'b0;
			restore_cnt_q <= 3'h0;
		end else if (clk_ok_q) begin
			restore_cnt_q <= 3'h0;
			if (gap_q == 11'(`LOSS_CYC - 1) && !sync_edge)
				clk_ok_q <= 1'b0;
		end else if (gap_q == 11'(`LOSS_CYC) && !sync_edge) begin
			restore_cnt_q <= 3'h0;
		end else if (sync_edge) begin
			if (restore_cnt_q == `RESTORE_EDGES - 3'h1) begin
				clk_ok_q <= 1'b1;
				restore_cnt_q <= 3'h0;
			end else begin
				restore_cnt_q <= restore_cnt_q + 3'h1;
			end
		end
	end

	a_loss_latency: assert property ($fell(clk_ok_q) |-> $past(gap_q) == LOSS_I - 1)
		else $error("clock loss not flagged at 10 us");
	a_restore_seven: assert property ($rose(clk_ok_q) |-> $past(restore_cnt_q) == 6)
		else $error("clock return not counted as seven edges");

	assign loss_off = misc_q[`MISC_LOSS_OFF_BIT];
	assign sync_flt = clk_role_q && !clk_ok_q && !loss_off;
	// any own fault or a low shared line halts switching
	assign run_ok = (!clk_role_q || clk_ok_q || loss_off) && share_q && !fault_in;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_DETECT: if (role_cnt_q == 11'(`ROLE_CYC - 1))
				state_d = ST_STRAP;
			ST_STRAP: if (strap.done)
				state_d = ST_OFF;
			ST_OFF: if (ctrl_q && run_ok)
				state_d = ST_RAMP;
			ST_RAMP: begin
				if (!ctrl_q)
					state_d = ST_OFF;
				else if (!run_ok)
					state_d = ST_HOLD;
				else if (frac_q == 11'(`RAMP_STEPS))
					state_d = ST_ON;
			end
			ST_ON: begin
				if (!ctrl_q)
					state_d = ST_OFF;
				else if (!run_ok)
					state_d = ST_HOLD;
			end
			ST_HOLD: begin
				if (!ctrl_q)
					state_d = ST_OFF;
				else if (run_ok)
					state_d = ST_RAMP;
			end
			default: state_d = ST_DETECT;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in)
			state_q <= ST_DETECT;
		else
			state_q <= state_d;
	end

	// switching follows the next state so a fault gates it at once
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			switch_enable_out <= 1'b0;
			softstart_busy_out <= 1'b0;
		end else begin
			switch_enable_out <= (state_d == ST_RAMP) || (state_d == ST_ON);
			softstart_busy_out <= state_d == ST_RAMP;
		end
	end

	a_no_clock_off: assert property (sync_flt |=> !switch_enable_out)
		else $error("switching while expected clock is missing");
	a_dis_runs_on: assert property (state_q == ST_ON && loss_off && ctrl_q && share_q
		&& !fault_in |=> state_q == ST_ON)
		else $error("shut down on clock loss with response disabled");

	// a clock-role phase runs slow from the slow count until the clock is flagged lost, master never does
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			freq_slow_out <= 1'b0;
			sync_out_oe_out <= 1'b0;
		end else begin
			freq_slow_out <= clk_role_q && clk_ok_q && gap_q >= 11'(`SLOW_CYC);
			sync_out_oe_out <= state_q != ST_DETECT && !clk_role_q;
		end
	end

	a_master_fast: assert property (!clk_role_q |=> !freq_slow_out)
		else $error("clock master left free-running frequency");
	a_dis_free_run: assert property (loss_off && !clk_ok_q |=> !freq_slow_out)
		else $error("still slow after clock loss detected");

	// shared line is open drain: only ever driven low
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			shared_loop_line_out <= 1'b0;
			shared_loop_line_oe_out <= 1'b0;
		end else begin
			shared_loop_line_out <= 1'b0;
			shared_loop_line_oe_out <= sync_flt || fault_in;
		end
	end

	a_share_pull: assert property (fault_in || sync_flt |=> shared_loop_line_oe_out)
		else $error("fault did not pull the shared line");
	a_share_stop: assert property (!share_q |=> !switch_enable_out)
		else $error("switching while shared line is low");

	// alert follows other faults only; strap and clock status stay silent
	always_ff @(posedge core_clk_in) begin
		if (reset_in)
			alert_out <= 1'b0;
		else
			alert_out <= fault_in;
	end

	a_no_sync_alert: assert property (sync_flt && !fault_in |=> !alert_out)
		else $error("sync fault raised the alert");

	assign rise_wr_ok = cmd_req_in.wr && cmd_req_in.code == `CMD_RISE_TIME
		&& strap_taken_q && cmd_req_in.wdata >= `RISE_MIN_MS
		&& cmd_req_in.wdata <= `RISE_MAX_MS;

	// strap value loads once per power-up; later writes of 1 to 100 ms replace it
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			rise_q <= `RISE_DEFAULT_MS;
			strap_taken_q <= 1'b0;
			strap_fail_q <= 1'b0;
		end else if (!strap_taken_q && strap.done) begin
			rise_q <= strap.rise_ms;
			strap_taken_q <= 1'b1;
			strap_fail_q <= strap.fail;
		end else if (rise_wr_ok) begin
			rise_q <= cmd_req_in.wdata;
		end
	end

	a_write_wins: assert property (rise_wr_ok |=> rise_q == $past(cmd_req_in.wdata))
		else $error("rise-time write not applied");
	a_rise_range: assert property (strap_taken_q && !strap.fail && nvm_rise_in >= 8'h01
		&& nvm_rise_in <= 8'h64 |-> rise_q >= 8'h01 && rise_q <= 8'h64)
		else $error("rise time outside 1 to 100 ms");

	always_ff @(posedge core_clk_in) begin
		if (reset_in)
			misc_q <= `MISC_CFG_RESET;
		else if (cmd_req_in.wr && cmd_req_in.code == `CMD_MISC_CFG)
			misc_q <= cmd_req_in.wdata;
	end

	// unmapped codes read as zero
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			cmd_rdata_out <= 8'h00;
		end else if (cmd_req_in.rd) begin
			case (cmd_req_in.code)
				`CMD_MFR_STATUS: begin
					cmd_rdata_out <= 8'h00;
					cmd_rdata_out[`STAT_SYNC_FLT_BIT] <= sync_flt;
					cmd_rdata_out[`STAT_STRAP_FAIL_BIT] <= strap_fail_q;
				end
				`CMD_MISC_CFG: cmd_rdata_out <= misc_q;
				`CMD_RISE_TIME: cmd_rdata_out <= rise_q;
				default: cmd_rdata_out <= 8'h00;
			endcase
		end
	end

	a_status_live: assert property (cmd_req_in.rd && cmd_req_in.code == 8'h80
		|=> cmd_rdata_out[0] == $past(sync_flt))
		else $error("status bit does not track clock state");

	// step length truncates 1 ms / 1024 to whole cycles: ramp is ~0.06% fast
	assign step_len = 14'(rise_q * `STEP_CYC);

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			step_cnt_q <= 14'h0000;
			frac_q <= 11'h000;
		end else if (state_q != ST_RAMP) begin
			step_cnt_q <= 14'h0000;
			if (state_q != ST_ON)
				frac_q <= 11'h000;
		end else if (frac_q != 11'(`RAMP_STEPS)) begin
			if (step_cnt_q == step_len - 14'h0001) begin
				step_cnt_q <= 14'h0000;
				frac_q <= frac_q + 11'h001;
			end else begin
				step_cnt_q <= step_cnt_q + 14'h0001;
			end
		end
	end

	assign vref_prod = 27'(vref_target_in) * 27'(frac_q);

	always_ff @(posedge core_clk_in) begin
		if (reset_in)
			vref_out <= 16'h0000;
		else
			vref_out <= vref_prod[25:10];
	end

	a_ramp_from_zero: assert property ($rose(state_q == ST_RAMP) |-> frac_q == 11'h000
		##1 vref_out == 16'h0000)
		else $error("soft-start did not begin at zero");

endmodule
`default_nettype wire

// file: sim/phase_partner.sv
/*
 * Far-side model: external sync clock source and the other phase sharing
 * the fault line.
 * Assumes the bench starts and stops the clock and asks for a pull-down.
 */
`default_nettype none
module phase_partner (
	input  wire logic run_in,
	input  wire logic pull_in,
	input  wire logic dut_oe_in,
	output logic      sync_out,
	output logic      share_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// 125 ns period; parks low while stopped, so a stale high never
	// fakes a clock input role at the next power-up
	initial begin
		sync_out = 1'b0;
		#3;
		forever begin
			#62.5;
			sync_out = run_in ? ~sync_out : 1'b0;
		end
	end

	// open drain with pull-up: either party pulling low wins
	assign share_out = !(pull_in || dut_oe_in);
endmodule
`default_nettype wire

// file: sim/tb_top.sv
/*
 * Self-checking bench for the sync fault and soft-start controller.
 * Assumes phase_partner and the design files are compiled before it.
 */
`include "softstart_regs.svh"
`default_nettype none
module tb_top
	import softstart_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rst, slave, ctrl, flt, sv, run, pull;
	logic        sen, slow, soe, shl, shl_oe, alert, busy, sync, share;
	logic [3:0]  code;
	logic [7:0]  nvm, rdata, q;
	logic [15:0] tgt, vref;
	cmd_req_t    cmd;
	int          err_total, compares, cyc, seed;

	sync_fault_softstart_ctrl i_sync_fault_softstart_ctrl (
		.core_clk_in(clk), .reset_in(rst), .sync_pin_in(sync),
		.loop_slave_strap_in(slave), .control_pin_in(ctrl),
		.shared_loop_line_in(share), .fault_in(flt), .strap_valid_in(sv),
		.strap_code_in(code), .nvm_rise_in(nvm), .vref_target_in(tgt),
		.cmd_req_in(cmd), .cmd_rdata_out(rdata), .switch_enable_out(sen),
		.freq_slow_out(slow), .sync_out_oe_out(soe), .shared_loop_line_out(shl),
		.shared_loop_line_oe_out(shl_oe), .alert_out(alert),
		.softstart_busy_out(busy), .vref_out(vref));

	phase_partner i_phase_partner (
		.run_in(run), .pull_in(pull), .dut_oe_in(shl_oe),
		.sync_out(sync), .share_out(share));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// run takes well under this; a hang lands here
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			err_total++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic [7:0] c, input logic w, input logic [7:0] d,
			output logic [7:0] r);
		@(posedge clk) cmd <= '{c, w, !w, d};
		@(posedge clk) cmd <= '0;
		#1 r = rdata;
	endtask

	// strap is sampled only after the detect window, so wait past it
	task automatic power_up(input logic [3:0] c, input logic s, input logic r);
		@(posedge clk) rst <= 1'b1;
		ctrl <= 1'b0;
		slave <= s;
		run <= r;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (1270) @(posedge clk);
		code <= c;
		repeat (16) begin
			@(posedge clk) sv <= 1'b1;
			@(posedge clk) sv <= 1'b0;
		end
		@(posedge clk) #1;
	endtask

	task automatic wait_sen;
		int n;
		n = 0;
		while (sen !== 1'b1 && n < 400) begin
			@(posedge clk) #1;
			n++;
		end
	endtask

	// interval between two reference steps tells the loaded rise time
	task automatic step_chk(input int ms);
		int n;
		logic [15:0] v;
		for (int k = 0; k < 2; k++) begin
			v = vref;
			n = 0;
			while (vref === v && n < 20000) begin
				@(posedge clk) #1;
				n++;
			end
		end
		chk(n, ms * `STEP_CYC);
	endtask

	function automatic int exp_ms(input int i);
		int t[9] = '{3, 1, 2, 3, 5, 7, 10, 27, 52};
		if (i == 9)
			return int'(nvm);
		if (i > 9)
			return 3;
		return t[i];
	endfunction

	initial begin
		seed = 47;
		rst = 1'b1;
		{slave, ctrl, flt, sv, pull} = '0;
		run = 1'b1;
		code = '0;
		cmd = '0;
		tgt = 16'hFFFF;
		nvm = 8'(1 + $unsigned($random(seed)) % 40);
		power_up(4'h4, 1'b0, 1'b1);
		chk(soe, 1'b0);
		bus(`CMD_MISC_CFG, 1'b0, 8'h00, q);
		chk(q, `MISC_CFG_RESET);
		bus(`CMD_RISE_TIME, 1'b1, 8'h00, q);
		bus(`CMD_RISE_TIME, 1'b1, 8'h65, q);
		bus(`CMD_RISE_TIME, 1'b0, 8'h00, q);
		chk(q, 8'h05);
		bus(`CMD_RISE_TIME, 1'b1, 8'h02, q);
		bus(`CMD_RISE_TIME, 1'b0, 8'h00, q);
		chk(q, 8'h02);
		bus(`CMD_MISC_CFG, 1'b1, 8'h01, q);
		bus(`CMD_MISC_CFG, 1'b0, 8'h00, q);
		chk(q, 8'h01);
		bus(`CMD_MFR_STATUS, 1'b1, 8'hFF, q);
		bus(`CMD_MFR_STATUS, 1'b0, 8'h00, q);
		chk(q, 8'h00);
		bus(8'h55, 1'b0, 8'h00, q);
		chk(q, 8'h00);
		bus(`CMD_MISC_CFG, 1'b1, 8'h00, q);
		@(posedge clk) ctrl <= 1'b1;
		step_chk(2);
		$display("test registers done");
		for (int i = 0; i < 11; i++) begin
			power_up(4'(i), 1'b0, 1'b1);
			bus(`CMD_MFR_STATUS, 1'b0, 8'h00, q);
			chk(q, (i == 10) ? 8'(1 << `STAT_STRAP_FAIL_BIT) : 8'h00);
			@(posedge clk) ctrl <= 1'b1;
			step_chk(exp_ms(i));
			chk(alert, 1'b0);
		end
		$display("test strap done");
		power_up(4'h2, 1'b1, 1'b1);
		@(posedge clk) ctrl <= 1'b1;
		wait_sen();
		@(posedge clk) run <= 1'b0;
		repeat (700) @(posedge clk);
		#1 chk(slow, 1'b1);
		chk(sen, 1'b1);
		repeat (600) @(posedge clk);
		#1 chk(sen, 1'b0);
		bus(`CMD_MFR_STATUS, 1'b0, 8'h00, q);
		chk(q[`STAT_SYNC_FLT_BIT], 1'b1);
		chk(alert, 1'b0);
		@(posedge clk) run <= 1'b1;
		repeat (60) @(posedge clk);
		#1 chk(sen, 1'b0);
		wait_sen();
		chk(busy, 1'b1);
		bus(`CMD_MFR_STATUS, 1'b0, 8'h00, q);
		chk(q[`STAT_SYNC_FLT_BIT], 1'b0);
		$display("test loss done");
		bus(`CMD_MISC_CFG, 1'b1, 8'h01, q);
		@(posedge clk) run <= 1'b0;
		repeat (700) @(posedge clk);
		#1 chk(slow, 1'b1);
		repeat (700) @(posedge clk);
		#1 chk(sen, 1'b1);
		chk(slow, 1'b0);
		bus(`CMD_MFR_STATUS, 1'b0, 8'h00, q);
		chk(q[`STAT_SYNC_FLT_BIT], 1'b0);
		$display("test disabled done");
		power_up(4'h2, 1'b1, 1'b0);
		@(posedge clk) ctrl <= 1'b1;
		repeat (2000) @(posedge clk);
		#1 chk(sen, 1'b0);
		@(posedge clk) run <= 1'b1;
		wait_sen();
		chk(sen, 1'b1);
		@(posedge clk) pull <= 1'b1;
		repeat (8) @(posedge clk);
		#1 chk(sen, 1'b0);
		@(posedge clk) pull <= 1'b0;
		wait_sen();
		@(posedge clk) flt <= 1'b1;
		repeat (8) @(posedge clk);
		#1 chk(shl_oe, 1'b1);
		chk(shl, 1'b0);
		chk(sen, 1'b0);
		@(posedge clk) flt <= 1'b0;
		$display("test never and shared done");
		power_up(4'h0, 1'b0, 1'b0);
		chk(soe, 1'b1);
		@(posedge clk) ctrl <= 1'b1;
		wait_sen();
		chk(sen, 1'b1);
		$display("test role done");
		summarize();
	end
endmodule
`default_nettype wire
